// ===== design/sdic_init_seq.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sdic_init_seq
  import sdic_pkg::*;
#(
  parameter int unsigned PAUSE_COUNT = PAUSE_CYCLES,
  parameter logic [31:0] MEM_BASE    = 32'h2000_0000,
  parameter logic [31:0] REG_BASE    = 32'hf000_0000
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [SW_ADDR_W-1:0] sw_addr_in,
  input  wire logic [31:0]          sw_wdata_in,
  input  wire logic                 sw_wr_in,
  input  wire logic                 sw_rd_in,
  output logic [31:0]               sw_rdata_out,
  input  wire logic                 dev_ack_in,
  output logic                      dev_req_out,
  output logic                      dev_is_mem_out,
  output logic [31:0]               dev_addr_out,
  output logic [31:0]               dev_wdata_out
);
  typedef enum logic [4:0] {
    S_IDLE, S_MEMDEV, S_CFG, S_TIM0, S_TIM1, S_LOWPWR, S_PAUSE,
    S_NOP_SEL, S_NOP_ACK, S_PRE_SEL, S_PRE_ACK, S_REF_SEL, S_REF_ACK,
    S_MR_SEL, S_MR_ACK, S_EMR_SEL, S_EMR_ACK, S_NORM_SEL, S_NORM_ACK,
    S_EXTRA_ACK, S_REFRESH, S_DONE
  } sdic_state_t;

  sdic_state_t state;
  sdic_state_t next_state;
  sdic_state_t after;
  logic        issued;
  logic        next_issued;
  logic [3:0]  ref_left;
  logic [3:0]  next_ref_left;
  logic [1:0]  mem_type;
  logic [1:0]  next_mem_type;
  logic        done;
  logic        next_done;
  logic [31:0] memdev;
  logic [31:0] cfg;
  logic [31:0] tim0;
  logic [31:0] tim1;
  logic [31:0] lowpwr;
  logic [31:0] refresh;
  logic [31:0] next_memdev;
  logic [31:0] next_cfg;
  logic [31:0] next_tim0;
  logic [31:0] next_tim1;
  logic [31:0] next_lowpwr;
  logic [31:0] next_refresh;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        busy;
  logic        is_lpddr;
  logic        is_lowpwr;
  logic        acc_start;
  logic        acc_is_mem;
  logic [31:0] acc_addr;
  logic [31:0] acc_data;
  logic        acc_idle;
  logic        acc_done;
  logic        pause_load;
  logic        pause_over;

  assign busy      = (state != S_IDLE);
  assign is_lpddr  = (mem_type == MEM_LPDDR1);
  assign is_lowpwr = (mem_type != MEM_SDR);

  // software registers, writes to setup ignored while a sequence runs
  always_comb begin
    next_memdev   = memdev;
    next_cfg      = cfg;
    next_tim0     = tim0;
    next_tim1     = tim1;
    next_lowpwr   = lowpwr;
    next_refresh  = refresh;
    next_mem_type = mem_type;
    if (sw_wr_in && !busy) begin
      unique case (sw_addr_in)
        SW_CTRL_OFS:    next_mem_type = sw_wdata_in[CTRL_TYPE_LSB +: 2];
        SW_MEMDEV_OFS:  next_memdev   = sw_wdata_in;
        SW_CFG_OFS:     next_cfg      = sw_wdata_in;
        SW_TIM0_OFS:    next_tim0     = sw_wdata_in;
        SW_TIM1_OFS:    next_tim1     = sw_wdata_in;
        SW_LOWPWR_OFS:  next_lowpwr   = sw_wdata_in;
        SW_REFRESH_OFS: next_refresh  = sw_wdata_in;
        default:        next_refresh  = refresh;
      endcase
    end
  end

  // read data stands one cycle after the read strobe
  always_comb begin
    next_rdata = 32'h0;
    if (sw_rd_in) begin
      unique case (sw_addr_in)
        SW_CTRL_OFS:    next_rdata = {29'h0, mem_type, 1'b0};
        SW_STATUS_OFS:  next_rdata = {19'h0, state, 6'h0, done, busy};
        SW_MEMDEV_OFS:  next_rdata = memdev;
        SW_CFG_OFS:     next_rdata = cfg;
        SW_TIM0_OFS:    next_rdata = tim0;
        SW_TIM1_OFS:    next_rdata = tim1;
        SW_LOWPWR_OFS:  next_rdata = lowpwr;
        SW_REFRESH_OFS: next_rdata = refresh;
        default:        next_rdata = 32'h0;
      endcase
    end
  end

  // access issued in each step and the step that follows it
  always_comb begin
    acc_is_mem = 1'b0;
    acc_addr   = REG_BASE | DEV_MODE_OFS;
    acc_data   = MODE_NORMAL;
    after      = S_IDLE;
    unique case (state)
      S_MEMDEV: begin
        acc_addr = REG_BASE | DEV_MEMDEV_OFS;
        acc_data = memdev;
        after    = S_CFG;
      end
      S_CFG: begin
        acc_addr = REG_BASE | DEV_CFG_OFS;
        acc_data = cfg;
        after    = S_TIM0;
      end
      S_TIM0: begin
        acc_addr = REG_BASE | DEV_TIM0_OFS;
        acc_data = tim0;
        after    = S_TIM1;
      end
      S_TIM1: begin
        acc_addr = REG_BASE | DEV_TIM1_OFS;
        acc_data = tim1;
        // low-power step only for low-power parts
        after    = is_lowpwr ? S_LOWPWR : S_PAUSE;
      end
      S_LOWPWR: begin
        acc_addr = REG_BASE | DEV_LOWPWR_OFS;
        acc_data = lowpwr;
        after    = is_lpddr ? S_NOP_SEL : S_PAUSE;
      end
      S_NOP_SEL: begin
        acc_data = MODE_NOP;
        after    = S_NOP_ACK;
      end
      S_PRE_SEL: begin
        acc_data = MODE_PRECHARGE;
        after    = S_PRE_ACK;
      end
      S_REF_SEL: begin
        acc_data = MODE_REFRESH;
        after    = S_REF_ACK;
      end
      S_MR_SEL: begin
        acc_data = MODE_LOAD_MR;
        after    = S_MR_ACK;
      end
      S_EMR_SEL: begin
        acc_data = MODE_LOAD_EMR;
        after    = S_EMR_ACK;
      end
      S_NORM_SEL: begin
        acc_data = MODE_NORMAL;
        after    = S_NORM_ACK;
      end
      S_NOP_ACK, S_PRE_ACK, S_REF_ACK, S_NORM_ACK, S_EXTRA_ACK: begin
        acc_is_mem = 1'b1;
        acc_addr   = MEM_BASE;
        acc_data   = ACK_DATA;
        unique case (state)
          // first NOP ack starts the clock
          S_NOP_ACK:   after = is_lpddr ? S_PAUSE : S_PRE_SEL;
          S_PRE_ACK:   after = S_REF_SEL;
          S_REF_ACK:   after = is_lpddr ? S_EMR_SEL : S_MR_SEL;
          S_NORM_ACK:  after = is_lpddr ? S_EXTRA_ACK : S_REFRESH;
          default:     after = S_REFRESH;
        endcase
      end
      S_MR_ACK: begin
        acc_is_mem = 1'b1;
        acc_addr   = MEM_BASE | 32'({BA_MR, BA_LSB'(0)});
        acc_data   = ACK_DATA;
        after      = is_lpddr ? S_NORM_SEL : (is_lowpwr ? S_EMR_SEL : S_NORM_SEL);
      end
      S_EMR_ACK: begin
        // bank bit 1 high, bit 0 low
        acc_is_mem = 1'b1;
        acc_addr   = MEM_BASE | 32'({BA_EMR, BA_LSB'(0)});
        acc_data   = ACK_DATA;
        after      = is_lpddr ? S_MR_SEL : S_NORM_SEL;
      end
      S_REFRESH: begin
        acc_addr = REG_BASE | DEV_REFRESH_OFS;
        acc_data = refresh;
        after    = S_DONE;
      end
      default: begin
        after = S_IDLE;
      end
    endcase
  end

  // step sequencer
  always_comb begin
    next_state    = state;
    next_issued   = issued;
    next_ref_left = ref_left;
    next_done     = done;
    acc_start     = 1'b0;
    pause_load    = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (sw_wr_in && sw_addr_in == SW_CTRL_OFS && sw_wdata_in[CTRL_START_BIT]) begin
          next_state = S_MEMDEV;
          next_done  = 1'b0;
        end
      end
      S_PAUSE: begin
        if (pause_over) begin
          next_state = is_lpddr ? S_PRE_SEL : S_NOP_SEL;
        end
      end
      S_DONE: begin
        next_done  = 1'b1;
        next_state = S_IDLE;
      end
      default: begin
        if (!issued && acc_idle) begin
          acc_start   = 1'b1;
          next_issued = 1'b1;
        end
        if (acc_done) begin
          next_issued = 1'b0;
          if (state == S_REF_SEL) begin
            next_ref_left = is_lpddr ? LPDDR_REF_COUNT : SDR_REF_COUNT;
          end
          if (state == S_REF_ACK && ref_left != 4'h1) begin
            next_ref_left = ref_left - 4'h1;
          end else begin
            next_state = after;
            pause_load = (after == S_PAUSE);
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state    <= S_IDLE;
      issued   <= 1'b0;
      ref_left <= 4'h0;
      done     <= 1'b0;
      mem_type <= MEM_SDR;
      memdev   <= 32'h0;
      cfg      <= 32'h0;
      tim0     <= 32'h0;
      tim1     <= 32'h0;
      lowpwr   <= 32'h0;
      refresh  <= REFRESH_RESET;
      rdata    <= 32'h0;
    end else begin
      state    <= next_state;
      issued   <= next_issued;
      ref_left <= next_ref_left;
      done     <= next_done;
      mem_type <= next_mem_type;
      memdev   <= next_memdev;
      cfg      <= next_cfg;
      tim0     <= next_tim0;
      tim1     <= next_tim1;
      lowpwr   <= next_lowpwr;
      refresh  <= next_refresh;
      rdata    <= next_rdata;
    end
  end

  assign sw_rdata_out = rdata;

  sdic_dev_access u_access (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .start_in       (acc_start),
    .is_mem_in      (acc_is_mem),
    .addr_in        (acc_addr),
    .data_in        (acc_data),
    .idle_out       (acc_idle),
    .done_out       (acc_done),
    .dev_ack_in     (dev_ack_in),
    .dev_req_out    (dev_req_out),
    .dev_is_mem_out (dev_is_mem_out),
    .dev_addr_out   (dev_addr_out),
    .dev_wdata_out  (dev_wdata_out)
  );

  sdic_pause_timer u_pause (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (pause_load),
    .count_in    (TIMER_W'(PAUSE_COUNT)),
    .expired_out (pause_over)
  );
endmodule
`default_nettype wire

// ===== design/sdic_pkg.sv
package sdic_pkg;
  // clock and pause timing
  localparam int unsigned CORE_CLK_MHZ    = 50;
  localparam int unsigned PAUSE_US        = 200;
  localparam int unsigned PAUSE_CYCLES    = PAUSE_US * CORE_CLK_MHZ;
  localparam int unsigned TIMER_W         = 16;

  // refresh interval default: interval in ns times device clock MHz, divided by 1000
  localparam int unsigned REFRESH_NS      = 15625;
  localparam int unsigned DEV_CLK_MHZ     = 100;
  localparam logic [31:0] REFRESH_RESET   = 32'(REFRESH_NS * DEV_CLK_MHZ / 1000);

  // software port register offsets
  localparam int unsigned SW_ADDR_W       = 8;
  localparam logic [7:0]  SW_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  SW_STATUS_OFS   = 8'h04;
  localparam logic [7:0]  SW_MEMDEV_OFS   = 8'h08;
  localparam logic [7:0]  SW_CFG_OFS      = 8'h0c;
  localparam logic [7:0]  SW_TIM0_OFS     = 8'h10;
  localparam logic [7:0]  SW_TIM1_OFS     = 8'h14;
  localparam logic [7:0]  SW_LOWPWR_OFS   = 8'h18;
  localparam logic [7:0]  SW_REFRESH_OFS  = 8'h1c;

  // control and status fields
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_TYPE_LSB   = 1;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_STEP_LSB   = 8;

  // memory kinds selected in the control register
  localparam logic [1:0]  MEM_SDR         = 2'h0;
  localparam logic [1:0]  MEM_LPSDR       = 2'h1;
  localparam logic [1:0]  MEM_LPDDR1      = 2'h2;

  // device register offsets
  localparam logic [31:0] DEV_MODE_OFS    = 32'h0000_0000;
  localparam logic [31:0] DEV_REFRESH_OFS = 32'h0000_0004;
  localparam logic [31:0] DEV_CFG_OFS     = 32'h0000_0008;
  localparam logic [31:0] DEV_TIM0_OFS    = 32'h0000_000c;
  localparam logic [31:0] DEV_TIM1_OFS    = 32'h0000_0010;
  localparam logic [31:0] DEV_LOWPWR_OFS  = 32'h0000_001c;
  localparam logic [31:0] DEV_MEMDEV_OFS  = 32'h0000_0020;

  // device command mode codes
  localparam logic [31:0] MODE_NORMAL     = 32'h0000_0000;
  localparam logic [31:0] MODE_NOP        = 32'h0000_0001;
  localparam logic [31:0] MODE_PRECHARGE  = 32'h0000_0002;
  localparam logic [31:0] MODE_LOAD_MR    = 32'h0000_0003;
  localparam logic [31:0] MODE_REFRESH    = 32'h0000_0004;
  localparam logic [31:0] MODE_LOAD_EMR   = 32'h0000_0005;

  // refresh repeat counts and bank address placement
  localparam logic [3:0]  SDR_REF_COUNT   = 4'h8;
  localparam logic [3:0]  LPDDR_REF_COUNT = 4'h2;
  localparam int unsigned BA_LSB          = 22;
  localparam logic [1:0]  BA_MR           = 2'h0;
  localparam logic [1:0]  BA_EMR          = 2'h2;
  localparam logic [31:0] ACK_DATA        = 32'h0000_0000;
endpackage

// ===== design/sdic_pause_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sdic_pause_timer
  import sdic_pkg::*;
(
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               load_in,
  input  wire logic [TIMER_W-1:0] count_in,
  output logic                    expired_out
);
  logic [TIMER_W-1:0] count;
  logic [TIMER_W-1:0] next_count;

  // down counter, reloaded on request
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = count_in;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expired_out = (count == '0);
endmodule
`default_nettype wire

// ===== design/sdic_dev_access.sv
`timescale 1ns/1ps
`default_nettype none
module sdic_dev_access (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic        is_mem_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] data_in,
  output logic             idle_out,
  output logic             done_out,
  input  wire logic        dev_ack_in,
  output logic             dev_req_out,
  output logic             dev_is_mem_out,
  output logic [31:0]      dev_addr_out,
  output logic [31:0]      dev_wdata_out
);
  logic        next_req;
  logic        next_is_mem;
  logic [31:0] next_addr;
  logic [31:0] next_data;

  // hold one write request until the device acknowledges it
  always_comb begin
    next_req    = dev_req_out;
    next_is_mem = dev_is_mem_out;
    next_addr   = dev_addr_out;
    next_data   = dev_wdata_out;
    if (dev_req_out && dev_ack_in) begin
      next_req = 1'b0;
    end else if (!dev_req_out && start_in) begin
      next_req    = 1'b1;
      next_is_mem = is_mem_in;
      next_addr   = addr_in;
      next_data   = data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      dev_req_out    <= 1'b0;
      dev_is_mem_out <= 1'b0;
      dev_addr_out   <= 32'h0;
      dev_wdata_out  <= 32'h0;
    end else begin
      dev_req_out    <= next_req;
      dev_is_mem_out <= next_is_mem;
      dev_addr_out   <= next_addr;
      dev_wdata_out  <= next_data;
    end
  end

  assign idle_out = !dev_req_out;
  assign done_out = dev_req_out && dev_ack_in;
endmodule
`default_nettype wire

// ===== dv/sdic_init_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdic_init_seq_checker
  import sdic_pkg::*;
#(
  parameter logic [31:0] MEM_BASE = 32'h2000_0000,
  parameter logic [31:0] REG_BASE = 32'hf000_0000
) (
  input wire logic                 core_clk_in,
  input wire logic                 rst_n_in,
  input wire logic [SW_ADDR_W-1:0] sw_addr_in,
  input wire logic [31:0]          sw_wdata_in,
  input wire logic                 sw_wr_in,
  input wire logic                 sw_rd_in,
  input wire logic [31:0]          sw_rdata_out,
  input wire logic                 dev_ack_in,
  input wire logic                 dev_req_out,
  input wire logic                 dev_is_mem_out,
  input wire logic [31:0]          dev_addr_out,
  input wire logic [31:0]          dev_wdata_out
);
  logic        started;
  logic [31:0] mode;
  logic        next_started;
  logic [31:0] next_mode;
  // software start seen, last mode sent
  always_comb begin
    next_started = started | (sw_wr_in & (sw_addr_in == SW_CTRL_OFS) & sw_wdata_in[0]);
    next_mode    = mode;
    if (dev_req_out && dev_ack_in && !dev_is_mem_out && dev_addr_out == (REG_BASE | DEV_MODE_OFS)) begin
      next_mode = dev_wdata_out;
    end
  end
  always_ff @(posedge core_clk_in) begin
    started <= rst_n_in & next_started;
    mode    <= rst_n_in ? next_mode : MODE_NORMAL;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_hs;  dev_req_out && dev_ack_in;  endsequence
  sequence s_wt;  dev_req_out && !dev_ack_in; endsequence
  sequence s_mem; dev_req_out && dev_is_mem_out; endsequence
  a_req_hold: assert property (s_wt |=> dev_req_out && $stable(dev_addr_out) && $stable(dev_wdata_out) && $stable(dev_is_mem_out))
    else $error("request changed before ack");
  a_req_drop: assert property (s_hs |=> !dev_req_out)
    else $error("request not dropped after ack");
  a_no_autostart: assert property ($rose(dev_req_out) |-> started)
    else $error("device write without software start");
  a_ack_data_zero: assert property (s_mem |-> dev_wdata_out == ACK_DATA)
    else $error("memory ack write carries data");
  a_mem_window: assert property (s_mem |-> (dev_addr_out & ~(32'h3 << BA_LSB)) == MEM_BASE)
    else $error("memory write outside window");
  a_mr_bank: assert property (s_mem and mode == MODE_LOAD_MR |-> dev_addr_out[BA_LSB+:2] == BA_MR)
    else $error("mode load bank bits wrong");
  a_emr_bank: assert property (s_mem and mode == MODE_LOAD_EMR |-> dev_addr_out[BA_LSB+:2] == BA_EMR)
    else $error("extended load bank bits wrong");
  a_refresh_last: assert property (s_hs and !dev_is_mem_out && dev_addr_out == (REG_BASE | DEV_REFRESH_OFS) |=> !dev_req_out [*3])
    else $error("write after refresh count");
  a_rd_idle: assert property (!sw_rd_in |=> sw_rdata_out == 32'h0)
    else $error("read data without strobe");
  a_unmapped_zero: assert property (sw_rd_in && sw_addr_in == 8'h20 |=> sw_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_start_reads0: assert property (sw_rd_in && sw_addr_in == SW_CTRL_OFS |=> !sw_rdata_out[CTRL_START_BIT])
    else $error("start bit reads one");
endmodule
`default_nettype wire

// ===== dv/sdic_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdic_dev_model
  import sdic_pkg::*;
#(
  parameter logic [31:0] REG_BASE = 32'hf000_0000
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic        is_mem_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             ack_out,
  output logic             clk_en_out,
  output logic [23:0]      cnt_out,
  output logic [31:0]      refresh_out
);
  logic [31:0] mode;
  logic [1:0]  wt;
  logic [3:0]  nop, pre, rfs, mr, emr, xfer;
  assign cnt_out = {nop, pre, rfs, mr, emr, xfer};
  // acks after a delay, decodes mode and memory writes
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      {nop, pre, rfs, mr, emr, xfer} <= 24'h0;
      {ack_out, clk_en_out} <= 2'h0;
      refresh_out <= 32'h0;
      mode <= MODE_NORMAL;
      wt <= {slow_in, slow_in};
    end else begin
      ack_out <= 1'b0;
      if (req_in && ack_out) begin
        wt <= {slow_in, slow_in};
        if (!is_mem_in) begin
          if (addr_in == (REG_BASE | DEV_MODE_OFS)) mode <= wdata_in;
          if (addr_in == (REG_BASE | DEV_REFRESH_OFS)) refresh_out <= wdata_in;
        end else begin
          case (mode)
            MODE_NOP: begin
              nop <= nop + 4'h1;
              clk_en_out <= 1'b1;
            end
            MODE_PRECHARGE: pre <= pre + 4'h1;
            MODE_REFRESH:   rfs <= rfs + 4'h1;
            MODE_LOAD_MR:   if (addr_in[BA_LSB+:2] == BA_MR) mr <= mr + 4'h1;
            MODE_LOAD_EMR:  if (addr_in[BA_LSB+:2] == BA_EMR) emr <= emr + 4'h1;
            default:        xfer <= xfer + 4'h1;
          endcase
        end
      end else if (req_in) begin
        if (wt == 2'h0) ack_out <= 1'b1;
        else wt <= wt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/sdic_init_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdic_init_seq_tb;
  import sdic_pkg::*;
  localparam int unsigned PAUSE = 20;
  localparam logic [31:0] MB    = 32'h2000_0000;
  localparam logic [31:0] RB    = 32'hf000_0000;
  typedef struct packed {
    logic        mem;
    logic        pz;
    logic        care;
    logic [31:0] addr;
    logic [31:0] data;
  } sdic_note_t;
  logic                 core_clk_in, rst_n_in, sw_wr_in, sw_rd_in, dev_ack_in, dev_req_out;
  logic                 dev_is_mem_out, slow, rd_d, clk_en;
  logic [SW_ADDR_W-1:0] sw_addr_in;
  logic [31:0]          sw_wdata_in, sw_rdata_out, dev_addr_out, dev_wdata_out, refr;
  logic [23:0]          cnt;
  logic [63:0]          re;
  logic [31:0]          setup[5];
  sdic_note_t           nt;
  sdic_note_t           dq[$];
  logic [63:0]          rq[$];
  int                   n_errors, total_checks, seed, idle_cnt, r, k;
  sdic_init_seq #(.PAUSE_COUNT(PAUSE), .MEM_BASE(MB), .REG_BASE(RB)) u_dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sw_addr_in(sw_addr_in),
    .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in),
    .sw_rdata_out(sw_rdata_out), .dev_ack_in(dev_ack_in), .dev_req_out(dev_req_out),
    .dev_is_mem_out(dev_is_mem_out), .dev_addr_out(dev_addr_out), .dev_wdata_out(dev_wdata_out));
  sdic_dev_model #(.REG_BASE(RB)) u_dev (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .slow_in(slow), .req_in(dev_req_out),
    .is_mem_in(dev_is_mem_out), .addr_in(dev_addr_out), .wdata_in(dev_wdata_out),
    .ack_out(dev_ack_in), .clk_en_out(clk_en), .cnt_out(cnt), .refresh_out(refr));
  // clock
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic rd, input logic [7:0] a, input logic [31:0] d);
    sw_wr_in <= w;
    sw_rd_in <= rd;
    sw_addr_in <= a;
    sw_wdata_in <= d;
    @(posedge core_clk_in);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    bus(1'b0, 1'b1, a, 32'h0);
  endtask
  task automatic note(input logic mem, pz, care, input logic [31:0] a, d);
    dq.push_back('{mem, pz, care, a, d});
  endtask
  task automatic cmd(input logic [31:0] md, input logic care, input logic [1:0] ba, input logic pz);
    note(1'b0, pz, 1'b1, RB | DEV_MODE_OFS, md);
    note(1'b1, 1'b0, care, MB | (32'(ba) << BA_LSB), ACK_DATA);
  endtask
  // read data and device write monitor
  always @(posedge core_clk_in) begin
    rd_d <= sw_rd_in;
    if (rd_d && rq.size() != 0) begin
      re = rq.pop_front();
      chk((sw_rdata_out & re[63:32]) === re[31:0], "read data");
    end
    if (dev_req_out && dev_ack_in) begin
      if (dq.size() == 0) chk(1'b0, "extra device write");
      else begin
        nt = dq.pop_front();
        chk(dev_is_mem_out === nt.mem && dev_wdata_out === nt.data, "device write");
        if (nt.care) chk(dev_addr_out === nt.addr, "device address");
        if (nt.pz) chk(idle_cnt >= PAUSE - 1, "pause too short");
      end
      idle_cnt = 0;
    end else if (!dev_req_out || !rst_n_in) idle_cnt++;
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge core_clk_in);
    n_errors++;
    test_done();
  end
  initial begin
    {seed, n_errors, total_checks, idle_cnt} = {32'd3, 96'd0};
    {rst_n_in, sw_wr_in, sw_rd_in, slow} = 4'h0;
    sw_addr_in = 8'h0;
    sw_wdata_in = 32'h0;
    for (r = 0; r < 3; r++) begin
      rst_n_in <= 1'b0;
      slow <= r[0];
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rdx(SW_STATUS_OFS, 32'h0, '1);
      rdx(SW_REFRESH_OFS, 32'h0000_061a, '1);
      rdx(8'h20, 32'h0, '1);
      rdx(SW_CTRL_OFS, 32'h0, 32'h1);
      for (k = 0; k < 5; k++) begin
        setup[k] = $random(seed);
        bus(1'b1, 1'b0, SW_MEMDEV_OFS + 8'(4 * k), setup[k]);
        rdx(SW_MEMDEV_OFS + 8'(4 * k), setup[k], '1);
        if (k < 4 || r != 0) note(1'b0, 1'b0, 1'b1, RB | (k == 0 ? DEV_MEMDEV_OFS :
          k == 1 ? DEV_CFG_OFS : k == 2 ? DEV_TIM0_OFS : k == 3 ? DEV_TIM1_OFS :
          DEV_LOWPWR_OFS), setup[k]);
      end
      if (r != 0) bus(1'b1, 1'b0, SW_REFRESH_OFS, 32'h0000_030d);
      if (r != 2) cmd(MODE_NOP, 1'b0, 2'h0, 1'b1);
      else cmd(MODE_NOP, 1'b0, 2'h0, 1'b0);
      cmd(MODE_PRECHARGE, 1'b0, 2'h0, r == 2);
      cmd(MODE_REFRESH, 1'b0, 2'h0, 1'b0);
      for (k = 1; k < (r == 2 ? LPDDR_REF_COUNT : SDR_REF_COUNT); k++) note(1'b1, 1'b0, 1'b0, MB, ACK_DATA);
      if (r == 2) cmd(MODE_LOAD_EMR, 1'b1, BA_EMR, 1'b0);
      cmd(MODE_LOAD_MR, 1'b1, BA_MR, 1'b0);
      if (r == 1) cmd(MODE_LOAD_EMR, 1'b1, BA_EMR, 1'b0);
      cmd(MODE_NORMAL, 1'b0, 2'h0, 1'b0);
      if (r == 2) note(1'b1, 1'b0, 1'b0, MB, ACK_DATA);
      note(1'b0, 1'b0, 1'b1, RB | DEV_REFRESH_OFS, r == 0 ? 32'h0000_061a : 32'h0000_030d);
      chk(clk_en === 1'b0, "clock enabled early");
      bus(1'b1, 1'b0, SW_CTRL_OFS, 32'({r[1:0], 1'b1}));
      rdx(SW_STATUS_OFS, 32'h1, 32'h3);
      bus(1'b1, 1'b0, SW_CTRL_OFS, 32'({r[1:0] ^ 2'h1, 1'b1}));
      bus(1'b0, 1'b0, 8'h0, 32'h0);
      for (k = 0; k < 3000 && dq.size() != 0; k++) @(posedge core_clk_in);
      chk(dq.size() == 0, "device writes missing");
      repeat (3) @(posedge core_clk_in);
      rdx(SW_STATUS_OFS, 32'h2, 32'h3);
      bus(1'b0, 1'b0, 8'h0, 32'h0);
      chk(cnt === {8'h11, r == 2 ? LPDDR_REF_COUNT : SDR_REF_COUNT, 4'h1, 4'(r != 0),
        4'(r == 2 ? 2 : 1)}, "counts");
      chk(clk_en === 1'b1 && refr === (r == 0 ? 32'h0000_061a : 32'h0000_030d), "clock or refresh");
    end
    test_done();
  end
endmodule
bind sdic_init_seq sdic_init_seq_checker #(.MEM_BASE(MEM_BASE), .REG_BASE(REG_BASE)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sw_addr_in(sw_addr_in),
  .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in),
  .sw_rdata_out(sw_rdata_out), .dev_ack_in(dev_ack_in), .dev_req_out(dev_req_out),
  .dev_is_mem_out(dev_is_mem_out), .dev_addr_out(dev_addr_out), .dev_wdata_out(dev_wdata_out));
`default_nettype wire
